// File: core/dac_frontend_cfg.svh
`ifndef DAC_FRONTEND_CFG_SVH
`define DAC_FRONTEND_CFG_SVH

// Register addresses, 7-bit field of the command byte
`define ADDR_DAC      7'h01
`define ADDR_CFG      7'h02
`define ADDR_ADC      7'h03
`define ADDR_STAT     7'h04
`define ADDR_ADCRES   7'h05

// Field positions
`define CFG_CRC_BIT   0
`define CFG_SDOD_BIT  1
`define ADC_BUFPD_BIT 0
`define STAT_ERR_BIT  0
`define CMD_RD_BIT    23

// Reset values
`define CFG_RST       16'h0003
`define ADC_RST       16'h0001
`define DAC_RST       16'h0000

// Frame lengths in bits, command alone and command plus check byte
`define LEN_CMD       6'h18
`define LEN_CRC       6'h20
`define CNT_MAX       6'h3F

// Check byte polynomial x^8+x^2+x+1, seed zero
`define CRC_POLY      8'h07
`define CRC_INIT      8'h00

// Code points of the output transfer, converter_voltage_out = code/2^16 * 2.2 V + 0.3 V
`define VMIN_MV       300
`define FSR_MV        2200
`define CODE_ERR_LO   16'h045D
`define CODE_RNG_MIN  16'h0BA2
`define CODE_RNG_MID  16'h68BA
`define CODE_RNG_MAX  16'hC5D1
`define CODE_ERR_HI   16'hDA2E

`endif

// File: core/dac_frontend_pkg.sv
package dac_frontend_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } frame_state_t;
  typedef logic [7:0]  crc_byte_t;
  typedef logic [15:0] reg_word_t;
endpackage

// File: core/crc_if.sv
`timescale 1ns/1ps
interface crc_if;
  logic      clr;
  logic      en;
  logic      din;
  logic [7:0] crc;
  modport calc (input clr, input en, input din, output crc);
  modport user (output clr, output en, output din, input crc);
endinterface

// File: core/crc8_serial.sv
`timescale 1ns/1ps
`include "dac_frontend_cfg.svh"
module crc8_serial (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  crc_if.calc       port
);
  import dac_frontend_pkg::*;

  crc_byte_t crc_q;
  crc_byte_t crc_d;
  logic      fb;

  // One bit per sampled clock, MSB first
  assign fb    = port.din ^ crc_q[7];
  assign crc_d = port.clr ? `CRC_INIT :
                 ({crc_q[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00));
  assign port.crc = crc_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst)
      crc_q <= `CRC_INIT;
    else if (i_ce && (port.clr || port.en))
      crc_q <= crc_d;
  end
endmodule

// File: core/dac_init_config_frontend.sv
// Contract
// - Check byte enforcement is on after reset
// - Commands act only with a correct check byte
// - Serial output disabled after reset
// - Read-back only while serial output enabled
// - Range 0 output spans 0.3 to 2.5 V
// - Output is code/2^16 times 2.2 plus 0.3
// - Serial output high impedance when off or deselected
`timescale 1ns/1ps
`include "dac_frontend_cfg.svh"
module dac_init_config_frontend (
  input  wire logic                       i_clk,
  input  wire logic                       i_nrst,
  input  wire logic                       i_ce,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_sclk,
  input  wire logic                       i_sdi,
  input  wire logic [11:0]                i_adc_result,
  output logic                            o_sdo,
  output logic                            o_sdo_oe,
  output dac_frontend_pkg::reg_word_t     o_dac_code,
  output logic                            o_crc_en,
  output logic                            o_serial_out_disable,
  output logic                            o_adc_buffer_powerdown,
  output logic                            o_crc_error
);
  import dac_frontend_pkg::*;

  frame_state_t state_q;
  frame_state_t state_d;
  logic         cs_n_q;
  logic         sclk_q;
  logic [31:0]  shift_q;
  logic [5:0]   cnt_q;
  logic [23:0]  rd_q;
  logic [23:0]  out_q;
  reg_word_t    cfg_q;
  reg_word_t    adc_q;
  reg_word_t    dac_q;
  logic         err_q;
  logic         sdo_q;
  logic         oe_q;

  crc_if crc_bus ();

  crc8_serial u_crc (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .port   (crc_bus.calc)
  );

  // Pin edge detection, inputs are synchronous to i_clk
  logic in_frame;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  assign in_frame = (state_q == ST_FRAME);
  assign start    = cs_n_q & ~i_cs_n;
  assign stop     = in_frame & ~cs_n_q & i_cs_n;
  assign rise     = in_frame & ~i_cs_n & i_sclk & ~sclk_q;
  assign fall     = in_frame & ~i_cs_n & ~i_sclk & sclk_q;

  // Only the 24 command bits feed the check engine
  assign crc_bus.clr = start;
  assign crc_bus.en  = rise & (cnt_q < `LEN_CMD);
  assign crc_bus.din = i_sdi;

  // Frame decode at the deselect edge
  logic        crc_on;
  logic        sdo_dis;
  logic        len_ok;
  logic [23:0] cmd;
  logic        crc_match;
  logic        accept;
  logic        crc_fail;
  logic        is_rd;
  logic [6:0]  addr;
  reg_word_t   wdata;
  assign crc_on    = cfg_q[`CFG_CRC_BIT];
  assign sdo_dis   = cfg_q[`CFG_SDOD_BIT];
  assign len_ok    = crc_on ? (cnt_q == `LEN_CRC) : (cnt_q == `LEN_CMD);
  assign cmd       = crc_on ? shift_q[31:8] : shift_q[23:0];
  assign crc_match = (shift_q[7:0] == crc_bus.crc);
  assign accept    = stop & len_ok & (~crc_on | crc_match);
  assign crc_fail  = stop & crc_on & (cnt_q == `LEN_CRC) & ~crc_match;
  assign is_rd     = cmd[`CMD_RD_BIT];
  assign addr      = cmd[22:16];
  assign wdata     = cmd[15:0];

  // Write strobes per register
  logic wr_any;
  logic wr_dac;
  logic wr_cfg;
  logic wr_adc;
  logic wr_stat;
  logic err_clr;
  assign wr_any  = i_ce & accept & ~is_rd;
  assign wr_dac  = wr_any & (addr == `ADDR_DAC);
  assign wr_cfg  = wr_any & (addr == `ADDR_CFG);
  assign wr_adc  = wr_any & (addr == `ADDR_ADC);
  assign wr_stat = wr_any & (addr == `ADDR_STAT);
  assign err_clr = wr_stat & wdata[`STAT_ERR_BIT];

  // Read mux; ADC results only through this path
  reg_word_t rdata;
  logic      rd_load;
  assign rdata = (addr == `ADDR_DAC)    ? dac_q :
                 (addr == `ADDR_CFG)    ? cfg_q :
                 (addr == `ADDR_ADC)    ? adc_q :
                 (addr == `ADDR_STAT)   ? {15'h0000, err_q} :
                 (addr == `ADDR_ADCRES) ? {4'h0, i_adc_result} :
                 16'h0000;
  // No read data is staged while the output is disabled
  assign rd_load = i_ce & accept & is_rd & ~sdo_dis;

  // Frame sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (start) state_d = ST_FRAME;
      ST_FRAME: if (i_cs_n) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      cs_n_q  <= 1'b1;
      sclk_q  <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      cs_n_q  <= i_cs_n;
      sclk_q  <= i_sclk;
    end
  end

  // Input shifter and bit count, count saturates on overlong frames
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_q <= 32'h00000000;
      cnt_q   <= 6'h00;
    end else if (i_ce) begin
      if (start) begin
        cnt_q <= 6'h00;
      end else if (rise) begin
        shift_q <= {shift_q[30:0], i_sdi};
        if (cnt_q != `CNT_MAX)
          cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // Registers; check and output-disable set after reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= `CFG_RST;
      adc_q <= `ADC_RST;
      dac_q <= `DAC_RST;
    end else begin
      if (wr_cfg)
        cfg_q <= wdata;
      if (wr_adc)
        adc_q <= wdata;
      if (wr_dac)
        dac_q <= wdata;
    end
  end

  // Sticky error; a new failure wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst)
      err_q <= 1'b0;
    else if (i_ce && crc_fail)
      err_q <= 1'b1;
    else if (err_clr)
      err_q <= 1'b0;
  end

  // Read data goes out in the following frame, MSB first on falling sclk
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_q  <= 24'h000000;
      out_q <= 24'h000000;
      sdo_q <= 1'b0;
    end else if (i_ce) begin
      if (rd_load)
        rd_q <= {cmd[23:16], rdata};
      if (start) begin
        out_q <= rd_q;
        sdo_q <= rd_q[23];
      end else if (fall) begin
        out_q <= {out_q[22:0], 1'b0};
        sdo_q <= out_q[22];
      end
    end
  end

  // Drive only when enabled and selected, so other devices can share
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst)
      oe_q <= 1'b0;
    else if (i_ce)
      oe_q <= ~sdo_dis & ~i_cs_n;
  end

  assign o_sdo                  = sdo_q;
  assign o_sdo_oe               = oe_q;
  assign o_dac_code             = dac_q;
  assign o_crc_en               = cfg_q[`CFG_CRC_BIT];
  assign o_serial_out_disable   = cfg_q[`CFG_SDOD_BIT];
  assign o_adc_buffer_powerdown = adc_q[`ADC_BUFPD_BIT];
  assign o_crc_error            = err_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_bad_frame;
    i_ce && crc_fail;
  endsequence
  sequence s_frame_open;
    i_ce && start ##1 in_frame;
  endsequence

  chk_crc_off_cause: assert property ($fell(o_crc_en) |-> $past(wr_cfg))
    else $error("check enable dropped without accepted write");
  chk_crc_gate: assert property ((i_ce && stop && !len_ok) |-> !accept)
    else $error("frame of wrong length accepted");
  chk_bad_discard: assert property (s_bad_frame |=> $stable(o_dac_code)
      && $stable(o_crc_en) && o_crc_error)
    else $error("bad check byte frame changed state");
  chk_error_sticky: assert property ((o_crc_error && !$past(err_clr))
      |-> $past(o_crc_error) || $past(crc_fail))
    else $error("error flag rose without a failed frame");
  chk_sdo_hiz: assert property (o_sdo_oe |-> $past(!sdo_dis && !i_cs_n))
    else $error("serial output driven while disabled or deselected");
  chk_sdo_off_rst: assert property (o_serial_out_disable |=> !o_sdo_oe)
    else $error("serial output enabled while disable set");
  // Accepted read with output disabled must leave staged data alone
  chk_read_gate: assert property ((i_ce && accept && is_rd && sdo_dis)
      |=> $stable(rd_q))
    else $error("read data staged with output disabled");
  chk_dac_update: assert property (wr_dac |=> o_dac_code == $past(wdata))
    else $error("code register missed a write");
  chk_frame_open: assert property (s_frame_open |-> cnt_q == 6'h00)
    else $error("bit count not cleared at frame start");
endmodule

// File: verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  logic sdo_last;
  logic sdo_wire;

  // No pull on the shared line: a released line shows the inverse
  assign sdo_wire = i_sdo_oe ? i_sdo : ~sdo_last;

  // Last level actually driven by the device
  always @(posedge i_clk) begin
    if (i_sdo_oe) begin
      sdo_last <= i_sdo;
    end
  end

  // Idle: deselected, serial clock parked low
  initial begin
    o_cs_n   = 1'b1;
    o_sclk   = 1'b0;
    o_sdi    = 1'b0;
    sdo_last = 1'b0;
  end

  // One frame MSB first; word already holds the check byte if needed
  task automatic frame(input logic [31:0] word, input int nbits,
                       output logic [23:0] rx, output logic oe_seen);
    rx      = '0;
    oe_seen = 1'b0;
    @(posedge i_clk) o_cs_n <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      @(posedge i_clk);
      o_sclk <= 1'b0;
      o_sdi  <= word[i];
      // Low phase of three cycles lets the reply bit settle
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      if (i >= nbits - 24) begin
        rx[i - (nbits - 24)] = sdo_wire;
      end
      oe_seen = oe_seen | i_sdo_oe;
      @(posedge i_clk);
      o_sclk <= 1'b1;
      @(posedge i_clk);
    end
    @(posedge i_clk) o_sclk <= 1'b0;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_sdi  <= ~o_sdi; // Released data line
    // Register effects land one cycle after the deselect is seen
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask
endmodule

// File: verif/tb_dac_init_config_frontend.sv
`timescale 1ns/1ps
module tb_dac_init_config_frontend;
  import dac_frontend_pkg::*;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic [11:0] adc_result;
  logic        sdo;
  logic        sdo_oe;
  reg_word_t   dac_code;
  logic        crc_en;
  logic        sdo_dis;
  logic        adc_buffer_powerdown;
  logic        crc_err;
  logic [23:0] reply;
  logic        oe_seen;
  logic        crc_on;
  int          err_total;
  int          comparisons;
  reg_word_t   codes [7] = '{16'h0000, 16'h045D, 16'h0BA2, 16'h68BA,
                             16'hC5D1, 16'hDA2E, 16'hFFFF};

  dac_init_config_frontend u_dut (
    .i_clk                  (clk),
    .i_nrst                 (nrst),
    .i_ce                   (ce),
    .i_cs_n                 (cs_n),
    .i_sclk                 (sclk),
    .i_sdi                  (sdi),
    .i_adc_result           (adc_result),
    .o_sdo                  (sdo),
    .o_sdo_oe               (sdo_oe),
    .o_dac_code             (dac_code),
    .o_crc_en               (crc_en),
    .o_serial_out_disable   (sdo_dis),
    .o_adc_buffer_powerdown (adc_buffer_powerdown),
    .o_crc_error            (crc_err)
  );

  spi_host_model u_host (
    .i_clk    (clk),
    .i_sdo    (sdo),
    .i_sdo_oe (sdo_oe),
    .o_cs_n   (cs_n),
    .o_sclk   (sclk),
    .o_sdi    (sdi)
  );

  // 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Own check byte model, kept apart from the design's
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic chk(input string name, input logic [23:0] exp,
                     input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  // Bad flips one check bit; short sends 24 bits while checking is on
  task automatic send(input logic [23:0] cmd, input logic bad,
                      input logic short_frame);
    if (crc_on && !short_frame) begin
      u_host.frame({cmd, crc8(cmd) ^ {7'h00, bad}}, 32, reply, oe_seen);
    end else begin
      u_host.frame({8'h00, cmd}, 24, reply, oe_seen);
    end
    chk("oe_deselected", 1'b0, sdo_oe);
  endtask

  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    summarize();
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    adc_result = 12'h5A3;
    crc_on = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("dac_code", 16'h0000, dac_code);
    chk("crc_en", 1'b1, crc_en);
    chk("sdo_dis", 1'b1, sdo_dis);
    chk("adc_buffer_powerdown", 1'b1, adc_buffer_powerdown);
    chk("crc_err", 1'b0, crc_err);
    chk("sdo_oe", 1'b0, sdo_oe);
    // Missing or wrong check byte leaves the code alone
    send(24'h0168BA, 1'b0, 1'b1);
    chk("dac_short", 16'h0000, dac_code);
    send(24'h0168BA, 1'b1, 1'b0);
    chk("dac_badcrc", 16'h0000, dac_code);
    chk("crc_err_set", 1'b1, crc_err);
    send(24'h040001, 1'b0, 1'b0);
    chk("crc_err_clr", 1'b0, crc_err);
    send(24'h0168BA, 1'b0, 1'b0);
    chk("dac_goodcrc", 16'h68BA, dac_code);
    // Reads while the output is disabled stay silent
    send(24'h820000, 1'b0, 1'b0);
    send(24'h820000, 1'b0, 1'b0);
    chk("oe_disabled", 1'b0, oe_seen);
    u_host.frame(32'h02002624, 32, reply, oe_seen);
    chk("crc_off", 1'b0, crc_en);
    chk("sdo_still_dis", 1'b1, sdo_dis);
    crc_on = 1'b0;
    send(24'h020024, 1'b0, 1'b0);
    chk("sdo_enabled", 1'b0, sdo_dis);
    send(24'h030000, 1'b0, 1'b0);
    chk("adc_buffer_powerdown_clr", 1'b0, adc_buffer_powerdown);
    // Every documented code point written and read back
    foreach (codes[k]) begin
      send({8'h01, codes[k]}, 1'b0, 1'b0);
      chk("dac_code", {8'h00, codes[k]}, dac_code);
      send(24'h810000, 1'b0, 1'b0);
      send(24'h810000, 1'b0, 1'b0);
      chk("readback", {8'h81, codes[k]}, reply);
      chk("oe_enabled", 1'b1, oe_seen);
    end
    // ADC result, config and status read back; unmapped write ignored
    send(24'h850000, 1'b0, 1'b0);
    send(24'h820000, 1'b0, 1'b0);
    chk("adc_result", 24'h8505A3, reply);
    send(24'h840000, 1'b0, 1'b0);
    chk("cfg_read", 24'h820024, reply);
    send(24'h00AAAA, 1'b0, 1'b0);
    chk("status_read", 24'h840000, reply);
    chk("dac_unmapped", 16'hFFFF, dac_code);
    summarize();
  end
endmodule
